/* rtl/bpe_top.v */
// parity error handling for both bridge interfaces with register slave
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`include "bpe_defines.vh"
// Functional notes
// - address parity error before claim: cycle is not claimed if that side's parity enable is set
// - upstream addr perr with upstream parity enable: withhold select ack
// - upstream addr perr: system error pin only with serr and parity enables
// - upstream addr perr, both enables: signaled serr status, irq bit if unmasked
// - upstream addr perr: detected parity status always, irq mirror if unmasked
// - downstream addr perr with downstream parity enable: withhold select ack
// - downstream addr perr: serr pin needs serr, downstream parity and serr enables
// - downstream addr perr: signaled serr status with serr and downstream parity enables
// - downstream addr perr: secondary detected parity always, irq mirror if unmasked
// - bad part of forwarded dual address cycle: bad parity on all parts
// - bad data travels with its bad parity, never regenerated
// - downstream read data perr: downstream perr pin two clocks later if enabled
// - downstream read data perr, enabled: data parity detected, master irq bit if unmasked
// - downstream read data perr: secondary detected parity always, irq if unmasked
// - downstream read data kept with parity in queue, dropped on invalidate
// - upstream read data perr: upstream perr pin two clocks later if enabled
// - upstream read data perr, enabled: data parity detected, master irq bit if unmasked
// - upstream read data perr: primary detected parity always, irq if unmasked
// - upstream read data kept with parity in queue, dropped on invalidate
// - no select ack within 5 clocks of frame means master abort
module bpe_top #(
  parameter DW = 32,
  parameter AW = 3
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          reset_i,
  // avalon-mm register slave
  input  wire [4:0]    avs_address_i,
  input  wire          avs_read_i,
  input  wire          avs_write_i,
  input  wire [31:0]   avs_writedata_i,
  output wire [31:0]   avs_readdata_o,
  output wire          avs_waitrequest_o,
  // upstream address phase
  input  wire          up_addr_valid_i,
  input  wire          up_addr_hit_i,
  input  wire          up_addr_perr_i,
  output wire          up_claim_o,
  // downstream address phase
  input  wire          dn_addr_valid_i,
  input  wire          dn_addr_hit_i,
  input  wire          dn_addr_perr_i,
  output wire          dn_claim_o,
  // upstream system error pin, open drain
  output wire          up_serr_n_o,
  output wire          up_serr_oe_o,
  // read data phase parity errors
  input  wire          up_rd_perr_i,
  input  wire          dn_rd_perr_i,
  // parity error pins
  output wire          up_perr_n_o,
  output wire          up_perr_oe_o,
  output wire          dn_perr_n_o,
  output wire          dn_perr_oe_o,
  // dual address cycle forwarded upstream
  input  wire          dac_start_i,
  input  wire          dac_part_perr_i,
  input  wire          fwd_done_i,
  input  wire          fwd_apar_i,
  output wire          fwd_apar_o,
  // downstream read queue: filled downstream, drained upstream
  input  wire          dq_wr_i,
  input  wire [DW-1:0] dq_wr_data_i,
  input  wire          dq_wr_par_i,
  output wire          dq_full_o,
  input  wire          dq_rd_i,
  output wire [DW-1:0] dq_rd_data_o,
  output wire          dq_rd_par_o,
  output wire          dq_empty_o,
  input  wire          dq_inv_i,
  // upstream read queue: filled upstream, drained downstream
  input  wire          uq_wr_i,
  input  wire [DW-1:0] uq_wr_data_i,
  input  wire          uq_wr_par_i,
  output wire          uq_full_o,
  input  wire          uq_rd_i,
  output wire [DW-1:0] uq_rd_data_o,
  output wire          uq_rd_par_o,
  output wire          uq_empty_o,
  input  wire          uq_inv_i
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [15:0]   pcmd_q;
  reg  [15:0]   bctl_q;
  reg  [7:0]    mask_q;
  reg  [15:0]   pstat_q;
  reg  [15:0]   pstat_d;
  reg  [15:0]   sstat_q;
  reg  [15:0]   sstat_d;
  reg  [7:0]    pirq_q;
  reg  [7:0]    pirq_d;
  reg  [7:0]    sirq_q;
  reg  [7:0]    sirq_d;
  reg           ack_q;
  reg  [31:0]   rdata_q;
  reg  [31:0]   rdata_d;
  reg           up_claim_q;
  reg           dn_claim_q;
  reg           serr_q;
  reg  [`BPE_PERR_DLY-1:0] up_perr_q;
  reg  [`BPE_PERR_DLY-1:0] dn_perr_q;
  reg           dac_bad_q;
  reg           fwd_apar_q;
  wire          wr_en;
  wire          up_per;
  wire          dn_per;
  wire          serr_en;
  wire          up_ap;
  wire          dn_ap;
  wire          up_rp;
  wire          dn_rp;
  wire          ev_up_serr;
  wire          ev_dn_serr;
  wire          ev_sse;
  wire          ev_pdpe;
  wire          ev_sdpe;
  wire          ev_pmdpd;
  wire          ev_smdpd;
  // ---------------------------------------------------------------
  // enable decode
  // ---------------------------------------------------------------
  assign up_per  = pcmd_q[`BPE_CMD_PER];
  assign dn_per  = bctl_q[`BPE_BCTL_PER];
  assign serr_en = pcmd_q[`BPE_CMD_SERR];
  assign up_ap   = up_addr_valid_i & up_addr_perr_i;
  assign dn_ap   = dn_addr_valid_i & dn_addr_perr_i;
  assign up_rp   = up_rd_perr_i;
  assign dn_rp   = dn_rd_perr_i;
  // ---------------------------------------------------------------
  // error events
  // ---------------------------------------------------------------
  // upstream pin fires on either side's address error
  assign ev_up_serr = up_ap & serr_en & up_per;
  assign ev_dn_serr = dn_ap & serr_en & dn_per & bctl_q[`BPE_BCTL_SERR];
  // status bit needs fewer enables than the pin for downstream errors
  assign ev_sse   = (up_ap & serr_en & up_per) | (dn_ap & serr_en & dn_per);
  assign ev_pdpe  = up_ap | up_rp;
  assign ev_sdpe  = dn_ap | dn_rp;
  assign ev_pmdpd = up_rp & up_per;
  assign ev_smdpd = dn_rp & dn_per;
  // ---------------------------------------------------------------
  // claim decisions
  // ---------------------------------------------------------------
  // withholding the claim lets the master time out after 5 clocks
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      up_claim_q <= 1'b0;
      dn_claim_q <= 1'b0;
    end else begin
      up_claim_q <= up_addr_valid_i & up_addr_hit_i & ~(up_addr_perr_i & up_per);
      dn_claim_q <= dn_addr_valid_i & dn_addr_hit_i & ~(dn_addr_perr_i & dn_per);
    end
  end
  assign up_claim_o = up_claim_q;
  assign dn_claim_o = dn_claim_q;
  // ---------------------------------------------------------------
  // system error pin
  // ---------------------------------------------------------------
  // one clock of low drive, pull-up restores the wire
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      serr_q <= 1'b0;
    end else begin
      serr_q <= ev_up_serr | ev_dn_serr;
    end
  end
  assign up_serr_n_o  = 1'b0;
  assign up_serr_oe_o = serr_q;
  // ---------------------------------------------------------------
  // parity error pins, two clocks after the data phase
  // ---------------------------------------------------------------
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      up_perr_q <= {`BPE_PERR_DLY{1'b0}};
      dn_perr_q <= {`BPE_PERR_DLY{1'b0}};
    end else begin
      up_perr_q <= {up_perr_q[`BPE_PERR_DLY-2:0], up_rp & up_per};
      dn_perr_q <= {dn_perr_q[`BPE_PERR_DLY-2:0], dn_rp & dn_per};
    end
  end
  // drives low for one clock only; no high turnaround cycle
  assign up_perr_n_o  = 1'b0;
  assign up_perr_oe_o = up_perr_q[`BPE_PERR_DLY-1];
  assign dn_perr_n_o  = 1'b0;
  assign dn_perr_oe_o = dn_perr_q[`BPE_PERR_DLY-1];
  // ---------------------------------------------------------------
  // dual address cycle parity poisoning
  // ---------------------------------------------------------------
  // a bad part anywhere spoils every forwarded part, so a split
  // into single address phases cannot hide the error
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dac_bad_q  <= 1'b0;
      fwd_apar_q <= 1'b0;
    end else begin
      if (dac_start_i) begin
        dac_bad_q <= dac_part_perr_i;
      end else if (dac_part_perr_i) begin
        dac_bad_q <= 1'b1;
      end else if (fwd_done_i) begin
        dac_bad_q <= 1'b0;
      end
      fwd_apar_q <= fwd_apar_i ^ dac_bad_q;
    end
  end
  assign fwd_apar_o = fwd_apar_q;
  // ---------------------------------------------------------------
  // read completion queues
  // ---------------------------------------------------------------
  // parity rides beside the data untouched; the master checks it
  bpe_rcq #(.DW(DW), .AW(AW)) u_dq (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_i      (dq_wr_i),
    .wr_data_i (dq_wr_data_i),
    .wr_par_i  (dq_wr_par_i),
    .full_o    (dq_full_o),
    .rd_i      (dq_rd_i),
    .rd_data_o (dq_rd_data_o),
    .rd_par_o  (dq_rd_par_o),
    .empty_o   (dq_empty_o),
    .inv_i     (dq_inv_i)
  );
  bpe_rcq #(.DW(DW), .AW(AW)) u_uq (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_i      (uq_wr_i),
    .wr_data_i (uq_wr_data_i),
    .wr_par_i  (uq_wr_par_i),
    .full_o    (uq_full_o),
    .rd_i      (uq_rd_i),
    .rd_data_o (uq_rd_data_o),
    .rd_par_o  (uq_rd_par_o),
    .empty_o   (uq_empty_o),
    .inv_i     (uq_inv_i)
  );
  // ---------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ---------------------------------------------------------------
  // write lands at the edge where waitrequest is seen low
  assign wr_en             = avs_write_i & ack_q;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign avs_readdata_o    = rdata_q;
  // read mux; unmapped offsets read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (avs_address_i)
      `BPE_OFS_PCMD:  rdata_d = {16'h0000, pcmd_q};
      `BPE_OFS_PSTAT: rdata_d = {16'h0000, pstat_q};
      `BPE_OFS_SSTAT: rdata_d = {16'h0000, sstat_q};
      `BPE_OFS_BCTL:  rdata_d = {16'h0000, bctl_q};
      `BPE_OFS_MASK:  rdata_d = {24'h000000, mask_q};
      `BPE_OFS_PIRQ:  rdata_d = {24'h000000, pirq_q};
      `BPE_OFS_SIRQ:  rdata_d = {24'h000000, sirq_q};
      default:        rdata_d = 32'h00000000;
    endcase
  end
  // ---------------------------------------------------------------
  // sticky status: set wins over a write-one clear
  // ---------------------------------------------------------------
  always @* begin
    pstat_d = pstat_q;
    sstat_d = sstat_q;
    pirq_d  = pirq_q;
    sirq_d  = sirq_q;
    if (wr_en && avs_address_i == `BPE_OFS_PSTAT) pstat_d = pstat_q & ~avs_writedata_i[15:0];
    if (wr_en && avs_address_i == `BPE_OFS_SSTAT) sstat_d = sstat_q & ~avs_writedata_i[15:0];
    if (wr_en && avs_address_i == `BPE_OFS_PIRQ)  pirq_d  = pirq_q & ~avs_writedata_i[7:0];
    if (wr_en && avs_address_i == `BPE_OFS_SIRQ)  sirq_d  = sirq_q & ~avs_writedata_i[7:0];
    // only software clears these bits
    if (ev_sse) begin
      pstat_d[`BPE_ST_SSE] = 1'b1;
      if (!mask_q[`BPE_MSK_SERR]) pirq_d[`BPE_IRQ_SERR] = 1'b1;
    end
    if (ev_pdpe) begin
      pstat_d[`BPE_ST_DPE] = 1'b1;
      if (!mask_q[`BPE_MSK_UDPE]) pirq_d[`BPE_IRQ_DPE] = 1'b1;
    end
    if (ev_pmdpd) begin
      pstat_d[`BPE_ST_MDPD] = 1'b1;
      if (!mask_q[`BPE_MSK_UMPE]) pirq_d[`BPE_IRQ_MPE] = 1'b1;
    end
    if (ev_sdpe) begin
      sstat_d[`BPE_ST_DPE] = 1'b1;
      if (!mask_q[`BPE_MSK_DDPE]) sirq_d[`BPE_IRQ_DPE] = 1'b1;
    end
    if (ev_smdpd) begin
      sstat_d[`BPE_ST_MDPD] = 1'b1;
      if (!mask_q[`BPE_MSK_DMPE]) sirq_d[`BPE_IRQ_MPE] = 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // register flops
  // ---------------------------------------------------------------
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
      pcmd_q  <= `BPE_RST_CMD;
      bctl_q  <= `BPE_RST_BCTL;
      mask_q  <= `BPE_RST_MASK;
      pstat_q <= 16'h0000;
      sstat_q <= 16'h0000;
      pirq_q  <= 8'h00;
      sirq_q  <= 8'h00;
    end else begin
      ack_q   <= (avs_read_i | avs_write_i) & ~ack_q;
      if (avs_read_i && !ack_q) begin
        rdata_q <= rdata_d;
      end
      if (wr_en && avs_address_i == `BPE_OFS_PCMD) pcmd_q <= avs_writedata_i[15:0];
      if (wr_en && avs_address_i == `BPE_OFS_BCTL) bctl_q <= avs_writedata_i[15:0];
      if (wr_en && avs_address_i == `BPE_OFS_MASK) mask_q <= avs_writedata_i[7:0];
      pstat_q <= pstat_d;
      sstat_q <= sstat_d;
      pirq_q  <= pirq_d;
      sirq_q  <= sirq_d;
    end
  end
endmodule // bpe_top

/* rtl/bpe_defines.vh */
// constants for the bridge parity error handler
`ifndef BPE_DEFINES_VH
`define BPE_DEFINES_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define BPE_OFS_PCMD  5'h00
`define BPE_OFS_PSTAT 5'h04
`define BPE_OFS_SSTAT 5'h08
`define BPE_OFS_BCTL  5'h0c
`define BPE_OFS_MASK  5'h10
`define BPE_OFS_PIRQ  5'h14
`define BPE_OFS_SIRQ  5'h18
// ---------------------------------------------------------------
// command and bridge control bits
// ---------------------------------------------------------------
`define BPE_CMD_PER   6
`define BPE_CMD_SERR  8
`define BPE_BCTL_PER  0
`define BPE_BCTL_SERR 1
// ---------------------------------------------------------------
// status bits (write one to clear)
// ---------------------------------------------------------------
`define BPE_ST_MDPD   8
`define BPE_ST_SSE    14
`define BPE_ST_DPE    15
// ---------------------------------------------------------------
// mask bits
// ---------------------------------------------------------------
`define BPE_MSK_UDPE  0
`define BPE_MSK_UMPE  1
`define BPE_MSK_SERR  2
`define BPE_MSK_DDPE  3
`define BPE_MSK_DMPE  4
// ---------------------------------------------------------------
// irq status bits (write one to clear)
// ---------------------------------------------------------------
`define BPE_IRQ_MPE   0
`define BPE_IRQ_DPE   2
`define BPE_IRQ_SERR  3
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define BPE_RST_CMD   16'h0000
`define BPE_RST_BCTL  16'h0000
`define BPE_RST_MASK  8'h00
`define BPE_PERR_DLY  2
`endif

/* rtl/bpe_rcq.v */
// read completion queue keeping data with its received parity
`timescale 1ns/1ns
module bpe_rcq #(
  parameter DW    = 32,
  parameter AW    = 3
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          reset_i,
  // fill side
  input  wire          wr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire          wr_par_i,
  output wire          full_o,
  // drain side
  input  wire          rd_i,
  output wire [DW-1:0] rd_data_o,
  output wire          rd_par_o,
  output wire          empty_o,
  // drop everything left, no report
  input  wire          inv_i
);
  localparam DEPTH = 1 << AW;
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  reg  [DW:0]   mem_q [0:DEPTH-1];
  reg  [AW:0]   wp_q;
  reg  [AW:0]   rp_q;
  wire          do_wr;
  wire          do_rd;
  assign full_o    = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty_o   = (wp_q == rp_q);
  assign do_wr     = wr_i & ~full_o;
  assign do_rd     = rd_i & ~empty_o;
  // parity bit kept as received, never regenerated
  assign rd_data_o = mem_q[rp_q[AW-1:0]][DW-1:0];
  assign rd_par_o  = mem_q[rp_q[AW-1:0]][DW];
  // array has no reset, only pointers do
  always @(posedge clk_i) begin
    if (do_wr) begin
      mem_q[wp_q[AW-1:0]] <= {wr_par_i, wr_data_i};
    end
  end
  // invalidate discards unread prefetched words silently
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else if (inv_i) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) wp_q <= wp_q + 1'b1;
      if (do_rd) rp_q <= rp_q + 1'b1;
    end
  end
endmodule // bpe_rcq

/* bench/bpe_chk.sv */
// concurrent checks on the parity error handler ports
`timescale 1ns/1ns
module bpe_chk #(
  parameter DW = 32
) (
  // clock and reset
  input wire          clk_i,
  input wire          reset_i,
  // address phases
  input wire          up_addr_valid_i,
  input wire          up_addr_hit_i,
  input wire          up_addr_perr_i,
  input wire          up_claim_o,
  input wire          dn_addr_valid_i,
  input wire          dn_addr_hit_i,
  input wire          dn_addr_perr_i,
  input wire          dn_claim_o,
  // error pins
  input wire          up_serr_oe_o,
  input wire          up_rd_perr_i,
  input wire          dn_rd_perr_i,
  input wire          up_perr_oe_o,
  input wire          dn_perr_oe_o,
  // dual address forwarding
  input wire          dac_start_i,
  input wire          dac_part_perr_i,
  input wire          fwd_done_i,
  input wire          fwd_apar_i,
  input wire          fwd_apar_o,
  // downstream read queue
  input wire          dq_wr_i,
  input wire [DW-1:0] dq_wr_data_i,
  input wire          dq_wr_par_i,
  input wire          dq_rd_i,
  input wire [DW-1:0] dq_rd_data_o,
  input wire          dq_rd_par_o,
  input wire          dq_empty_o,
  input wire          dq_inv_i
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // a claim answers only a decoded address phase
  claim_cause_a: assert property (up_claim_o |-> $past(up_addr_valid_i && up_addr_hit_i))
    else $error("upstream claim without decoded address");
  up_claim_a: assert property (up_addr_valid_i && up_addr_hit_i && !up_addr_perr_i |=> up_claim_o)
    else $error("clean upstream address not claimed");
  dn_claim_a: assert property (dn_addr_valid_i && dn_addr_hit_i && !dn_addr_perr_i |=> dn_claim_o)
    else $error("clean downstream address not claimed");
  // system error only one clock after a bad address on either bus
  serr_cause_a: assert property (up_serr_oe_o |->
    $past(up_addr_valid_i && up_addr_perr_i || dn_addr_valid_i && dn_addr_perr_i))
    else $error("system error without bad address");
  up_perr_dly_a: assert property (up_perr_oe_o |-> $past(up_rd_perr_i, 2))
    else $error("upstream parity pin off its slot");
  dn_perr_dly_a: assert property (dn_perr_oe_o |-> $past(dn_rd_perr_i, 2))
    else $error("downstream parity pin off its slot");
  // once flagged, the next forwarded parity comes out inverted
  dac_bad_a: assert property (dac_part_perr_i ##1 !(fwd_done_i || dac_start_i)
    |=> fwd_apar_o == !$past(fwd_apar_i))
    else $error("forwarded address parity not bad");
  // a word keeps its received parity in the queue
  dq_keep_a: assert property (dq_wr_i && dq_empty_o && !dq_rd_i && !dq_inv_i |=>
    !dq_empty_o && dq_rd_data_o == $past(dq_wr_data_i) && dq_rd_par_o == $past(dq_wr_par_i))
    else $error("queued word or parity altered");
  dq_drop_a: assert property (dq_inv_i && !dq_wr_i |=> dq_empty_o)
    else $error("queue not emptied by invalidate");
  // main scenarios
  serr_c: cover property (up_serr_oe_o);
  perr_c: cover property (dn_perr_oe_o);
  inv_c: cover property (dq_inv_i && !dq_empty_o);
endmodule // bpe_chk
bind bpe_top bpe_chk #(.DW(DW)) bpe_chk_i (.*);

/* bench/bpe_bus_model.sv */
// bus-side model: masters and targets on one bridge bus
`timescale 1ns/1ns
module bpe_bus_model (
  // clock and bridge answer
  input  wire        clk_i,
  input  wire        claim_i,
  // read data returned to the initiator
  input  wire [31:0] rd_data_i,
  input  wire        rd_par_i,
  input  wire        pop_i,
  // bus events
  output reg         valid_o,
  output reg         hit_o,
  output reg         perr_o,
  output reg         rd_perr_o,
  output reg         master_perr_o
);
  initial {valid_o, hit_o, perr_o, rd_perr_o, master_perr_o} = 5'h00;
  // address phase; qualifiers flip once released so stale values never help
  task addr(input h, input e, output ab);
    ab = 1'b1;
    @(posedge clk_i);
    {valid_o, hit_o, perr_o} <= {1'b1, h, e};
    @(posedge clk_i);
    {valid_o, hit_o, perr_o} <= {1'b0, ~h, ~e};
    repeat (5) begin
      @(negedge clk_i);
      if (claim_i === 1'b1) ab = 1'b0;
    end
  endtask
  // one data phase with bad parity
  task rdperr;
    @(posedge clk_i);
    rd_perr_o <= 1'b1;
    @(posedge clk_i);
    rd_perr_o <= 1'b0;
  endtask
  // initiator checks even parity of every word it takes
  always @(posedge clk_i)
    if (pop_i) master_perr_o <= (rd_par_i !== ^rd_data_i);
endmodule // bpe_bus_model

/* bench/bpe_top_tb.sv */
// self-checking bench for the bridge parity error handler
`timescale 1ns/1ns
module bpe_top_tb;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  reg         clk_i, reset_i, avs_read_i, avs_write_i, clr, p, s, dp, ds, m, ab_u, ab_d, ab_c;
  reg  [4:0]  avs_address_i;
  reg  [31:0] avs_writedata_i, dq_wr_data_i, uq_wr_data_i, rv;
  reg         dac_start_i, dac_part_perr_i, fwd_done_i, fwd_apar_i, dq_wr_i, dq_wr_par_i, dq_rd_i;
  reg         dq_inv_i, uq_wr_i, uq_wr_par_i, uq_rd_i, uq_inv_i;
  reg  [2:0]  seen;
  wire        up_addr_valid_i, up_addr_hit_i, up_addr_perr_i, up_rd_perr_i, up_claim_o, up_serr_n_o;
  wire        dn_addr_valid_i, dn_addr_hit_i, dn_addr_perr_i, dn_rd_perr_i, dn_claim_o, up_serr_oe_o;
  wire        up_perr_n_o, up_perr_oe_o, dn_perr_n_o, dn_perr_oe_o, fwd_apar_o, avs_waitrequest_o;
  wire        dq_full_o, dq_empty_o, dq_rd_par_o, uq_full_o, uq_empty_o, uq_rd_par_o, up_mp, dn_mp;
  wire [31:0] avs_readdata_o, dq_rd_data_o, uq_rd_data_o;
  integer     err_count, checked, cyc, j, k;
  bpe_top bpe_top_i (.*);
  bpe_bus_model bpe_bus_model_up (.clk_i(clk_i), .claim_i(up_claim_o), .rd_data_i(dq_rd_data_o),
    .rd_par_i(dq_rd_par_o), .pop_i(dq_rd_i), .valid_o(up_addr_valid_i), .hit_o(up_addr_hit_i),
    .perr_o(up_addr_perr_i), .rd_perr_o(up_rd_perr_i), .master_perr_o(up_mp));
  bpe_bus_model bpe_bus_model_dn (.clk_i(clk_i), .claim_i(dn_claim_o), .rd_data_i(uq_rd_data_o),
    .rd_par_i(uq_rd_par_o), .pop_i(uq_rd_i), .valid_o(dn_addr_valid_i), .hit_o(dn_addr_hit_i),
    .perr_o(dn_addr_perr_i), .rd_perr_o(dn_rd_perr_i), .master_perr_o(dn_mp));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // sticky pin monitor; the bench clears it between cases
  always @(posedge clk_i)
    seen <= clr ? 3'b000 : seen | {up_serr_oe_o, up_perr_oe_o, dn_perr_oe_o};
  // hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input [31:0] g, input [31:0] e);
    checked = checked + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk1(input g, input e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  // avalon cycles hold until waitrequest is seen low at an edge
  task wr(input [4:0] a, input [31:0] d);
    @(posedge clk_i);
    {avs_address_i, avs_writedata_i, avs_write_i} <= {a, d, 1'b1};
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
  endtask
  task rc(input [4:0] a, input [31:0] e);
    @(posedge clk_i);
    {avs_address_i, avs_read_i} <= {a, 1'b1};
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rv = avs_readdata_o;
    avs_read_i <= 1'b0;
    chk(rv, e);
  endtask
  task end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {err_count, checked, cyc} = 0;
    {avs_read_i, avs_write_i, clr, dac_start_i, dac_part_perr_i, fwd_done_i, fwd_apar_i} = 7'h00;
    {dq_wr_i, dq_wr_par_i, dq_rd_i, dq_inv_i, uq_wr_i, uq_wr_par_i, uq_rd_i, uq_inv_i} = 8'h00;
    {avs_address_i, avs_writedata_i, dq_wr_data_i, uq_wr_data_i} = 0;
    reset_i = 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    wr(5'h1c, 32'hffff_ffff);
    for (j = 0; j < 8; j = j + 1)
      rc(5'(j * 4), 32'h0);
    $display("test reset done");
    // address errors first half, read data errors second half
    for (j = 0; j < 64; j = j + 1) begin
      {m, ds, dp, s, p} = j[4:0];
      for (k = 1; k < 7; k = k + 1)
        wr(5'(k * 4), 32'hffff);
      wr(5'h00, {23'h0, s, 1'b0, p, 6'h00});
      wr(5'h0c, {30'h0, ds, dp});
      wr(5'h10, {27'h0, {5{m}}});
      @(posedge clk_i) clr <= 1'b1;
      @(posedge clk_i) clr <= 1'b0;
      if (j < 32) begin
        bpe_bus_model_up.addr(1'b1, 1'b1, ab_u);
        bpe_bus_model_dn.addr(1'b1, 1'b1, ab_d);
      end else begin
        bpe_bus_model_up.rdperr;
        bpe_bus_model_dn.rdperr;
      end
      bpe_bus_model_up.addr(1'b1, 1'b0, ab_c);
      chk1(ab_c, 1'b0);
      bpe_bus_model_dn.addr(1'b0, 1'b0, ab_c);
      chk1(ab_c, 1'b1);
      // error pins only ever pull low
      chk({29'h0, up_serr_n_o, up_perr_n_o, dn_perr_n_o}, 32'h0);
      if (j < 32) begin
        chk1(ab_u, p);
        chk1(ab_d, dp);
        chk1(seen[2], s & (p | dp & ds));
        rc(5'h04, {16'h0, 1'b1, s & (p | dp), 14'h0});
        rc(5'h08, 32'h8000);
        rc(5'h14, {28'h0, ~m & s & (p | dp), ~m, 2'b00});
        rc(5'h18, {29'h0, ~m, 2'b00});
      end else begin
        chk1(seen[1], p);
        chk1(seen[0], dp);
        rc(5'h04, {16'h0, 1'b1, 6'h00, p, 8'h00});
        rc(5'h08, {16'h0, 1'b1, 6'h00, dp, 8'h00});
        rc(5'h14, {29'h0, ~m, 1'b0, p & ~m});
        rc(5'h18, {29'h0, ~m, 1'b0, dp & ~m});
      end
    end
    $display("test address and data errors done");
    // bad dual address first, then a clean one after the done pulse
    for (j = 1; j >= 0; j = j - 1) begin
      @(posedge clk_i);
      {dac_start_i, dac_part_perr_i} <= {1'b1, j[0]};
      @(posedge clk_i);
      {dac_start_i, dac_part_perr_i} <= 2'b00;
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge clk_i) fwd_apar_i <= k[0];
        @(posedge clk_i);
        @(negedge clk_i) chk1(fwd_apar_o, k[0] ^ j[0]);
      end
      @(posedge clk_i) fwd_done_i <= 1'b1;
      @(posedge clk_i) fwd_done_i <= 1'b0;
    end
    $display("test dual address done");
    // fill past full with bad parity on odd words, take three, drop the rest
    for (k = 0; k < 9; k = k + 1) begin
      rv = 32'h5a5a_0000 + k;
      @(posedge clk_i);
      {dq_wr_i, uq_wr_i, dq_wr_data_i, uq_wr_data_i} <= {2'b11, rv, rv};
      {dq_wr_par_i, uq_wr_par_i} <= {2{^rv ^ k[0]}};
    end
    @(posedge clk_i) {dq_wr_i, uq_wr_i} <= 2'b00;
    @(negedge clk_i) chk({30'h0, dq_full_o, uq_full_o}, 32'h3);
    for (k = 0; k < 3; k = k + 1) begin
      rv = 32'h5a5a_0000 + k;
      @(negedge clk_i) chk(dq_rd_data_o, rv);
      chk(uq_rd_data_o, rv);
      chk({30'h0, dq_rd_par_o, uq_rd_par_o}, {30'h0, {2{^rv ^ k[0]}}});
      @(posedge clk_i) {dq_rd_i, uq_rd_i} <= 2'b11;
      @(posedge clk_i) {dq_rd_i, uq_rd_i} <= 2'b00;
      @(negedge clk_i) chk({30'h0, up_mp, dn_mp}, {30'h0, {2{k[0]}}});
    end
    @(posedge clk_i) {dq_inv_i, uq_inv_i} <= 2'b11;
    @(posedge clk_i) {dq_inv_i, uq_inv_i} <= 2'b00;
    @(negedge clk_i) chk({30'h0, dq_empty_o, uq_empty_o}, 32'h3);
    $display("test queues done");
    end_sim;
  end
endmodule // bpe_top_tb
